// file: logic/phy_status_ident_advert_regs.sv
// Port status, identifier and advertisement registers behind a serial management slave
`timescale 1ns/1ps
module phy_status_ident_advert_regs
    import phy_regs_pkg::*;
#(
    parameter logic [15:0] IDENT_HIGH = 16'h1234,  // Arbitrary value
    parameter logic [15:0] IDENT_LOW = 16'h5670,   // Arbitrary value
    parameter bit CAP_100TX_HD = 1'b1,
    parameter bit CAP_10_HD = 1'b1
) (
    input wire logic clk,               // System clock
    input wire logic rst_n,             // Synchronous reset, active low
    input wire logic soft_reset,        // Soft reset pulse from control
    input wire logic [4:0] port_addr,   // Port address pins
    input wire logic mdc,               // Management clock pin
    input wire logic mdio_in,           // Management data pin level
    output logic mdio_out,              // Management data driven level
    output logic mdio_oe_n,             // Drive enable, low drives
    input wire logic link_ok,           // Link monitor: link valid
    input wire logic jabber_event,      // Jabber detector event
    input wire logic speed_10,          // Port running at 10 Mbps
    input wire logic an_complete,       // Negotiation engine done
    output logic [15:0] advert          // Advertised word to engine
);
    import phy_regs_pkg::*;

    // ****************************************
    // Pin synchronisation
    // ****************************************
    logic [6:0] pins_s;
    logic mdc_s;
    logic mdio_s;
    logic [4:0] addr_s;

    pin_sync #(
        .WIDTH(7)
    ) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d({mdc, mdio_in, port_addr}),
        .q(pins_s)
    );

    assign mdc_s = pins_s[6];
    assign mdio_s = pins_s[5];
    assign addr_s = pins_s[4:0];

    logic mdc_d;
    logic mdc_rise;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mdc_d <= 1'b0;
        end else begin
            mdc_d <= mdc_s;
        end
    end

    assign mdc_rise = mdc_s & ~mdc_d;

    // ****************************************
    // Status latches
    // ****************************************
    latch_if lat ();
    logic next_read_clear;
    logic an_done;
    logic next_an_done;

    // Clear lands on the snapshot edge, so no event slips between
    assign lat.read_clear = next_read_clear;
    assign lat.link_raw = link_ok;
    assign lat.jabber_raw = jabber_event & speed_10;

    status_latch u_latch (
        .clk(clk),
        .rst_n(rst_n),
        .soft_reset(soft_reset),
        .lat(lat)
    );

    always_comb begin
        next_an_done = an_complete & ~soft_reset;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            an_done <= 1'b0;
        end else begin
            an_done <= next_an_done;
        end
    end

    // ****************************************
    // Read data selection
    // ****************************************
    logic [15:0] status_word;
    logic [15:0] rd_word;

    always_comb begin
        status_word = WORD_ZERO;
        status_word[STS_100TX_HD] = CAP_100TX_HD;
        status_word[STS_10_HD] = CAP_10_HD;
        status_word[STS_AN_DONE] = an_done;
        status_word[STS_LINK] = lat.link_latched;
        status_word[STS_JABBER] = lat.jabber_latched;
        status_word[STS_EXT_CAP] = 1'b1;
    end

    // ****************************************
    // Management frame engine
    // ****************************************
    frame_state_t state;
    frame_state_t next_state;
    logic [5:0] pre_cnt;
    logic [5:0] next_pre_cnt;
    logic [3:0] bit_cnt;
    logic [3:0] next_bit_cnt;
    logic [15:0] shift;
    logic [15:0] next_shift;
    logic [1:0] op;
    logic [1:0] next_op;
    logic hit;
    logic next_hit;
    logic [4:0] reg_num;
    logic [4:0] next_reg_num;
    logic [15:0] rd_shift;
    logic [15:0] next_rd_shift;
    logic next_mdio_out;
    logic next_mdio_oe_n;
    logic [15:0] next_advert;
    logic adv_wr_en;
    logic load_rd;
    logic drive_zero;
    logic drive_next;
    logic release_pin;
    logic [15:0] wr_word;

    assign wr_word = {shift[14:0], mdio_s};

    always_comb begin
        case (wr_word[4:0])
            REG_BASIC_STATUS: rd_word = status_word;
            REG_IDENT_HIGH: rd_word = IDENT_HIGH;
            REG_IDENT_LOW: rd_word = IDENT_LOW;
            REG_ADVERT: rd_word = advert;
            default: rd_word = WORD_ZERO;
        endcase
    end

    always_comb begin
        next_state = state;
        next_pre_cnt = pre_cnt;
        next_bit_cnt = bit_cnt;
        next_shift = shift;
        next_op = op;
        next_hit = hit;
        next_reg_num = reg_num;
        next_read_clear = 1'b0;
        adv_wr_en = 1'b0;
        load_rd = 1'b0;
        drive_zero = 1'b0;
        drive_next = 1'b0;
        release_pin = 1'b0;
        if (mdc_rise) begin
            case (state)
                ST_PREAMBLE: begin
                    if (mdio_s) begin
                        if (pre_cnt != PREAMBLE_LEN) begin
                            next_pre_cnt = pre_cnt + 6'h01;
                        end
                    end else if (pre_cnt == PREAMBLE_LEN) begin
                        next_state = ST_START;
                    end else begin
                        next_pre_cnt = 6'h00;
                    end
                end
                ST_START: begin
                    next_pre_cnt = 6'h00;
                    next_bit_cnt = 4'h0;
                    next_state = mdio_s ? ST_OP : ST_PREAMBLE;
                end
                ST_OP: begin
                    next_shift = wr_word;
                    next_bit_cnt = bit_cnt + 4'h1;
                    if (bit_cnt == 4'h1) begin
                        next_op = wr_word[1:0];
                        next_bit_cnt = 4'h0;
                        if (wr_word[1:0] == OP_READ || wr_word[1:0] == OP_WRITE) begin
                            next_state = ST_PHYAD;
                        end else begin
                            next_state = ST_PREAMBLE;
                        end
                    end
                end
                ST_PHYAD: begin
                    next_shift = wr_word;
                    next_bit_cnt = bit_cnt + 4'h1;
                    if (bit_cnt == FIELD5_LAST) begin
                        next_hit = (wr_word[4:0] == addr_s);
                        next_bit_cnt = 4'h0;
                        next_state = ST_REGAD;
                    end
                end
                ST_REGAD: begin
                    next_shift = wr_word;
                    next_bit_cnt = bit_cnt + 4'h1;
                    if (bit_cnt == FIELD5_LAST) begin
                        next_reg_num = wr_word[4:0];
                        next_bit_cnt = 4'h0;
                        next_state = ST_TURN;
                        load_rd = 1'b1;
                        if (hit && op == OP_READ && wr_word[4:0] == REG_BASIC_STATUS) begin
                            next_read_clear = 1'b1;
                        end
                    end
                end
                ST_TURN: begin
                    next_bit_cnt = bit_cnt + 4'h1;
                    if (hit && op == OP_READ) begin
                        drive_zero = 1'b1;
                    end
                    if (bit_cnt == 4'h1) begin
                        next_bit_cnt = 4'h0;
                        next_state = ST_DATA;
                        drive_next = hit && op == OP_READ;
                    end
                end
                ST_DATA: begin
                    next_bit_cnt = bit_cnt + 4'h1;
                    next_shift = wr_word;
                    drive_next = hit && op == OP_READ;
                    if (bit_cnt == DATA_LAST) begin
                        next_state = ST_PREAMBLE;
                        next_pre_cnt = 6'h00;
                        next_bit_cnt = 4'h0;
                        release_pin = 1'b1;
                        adv_wr_en = hit && op == OP_WRITE && reg_num == REG_ADVERT;
                    end
                end
                default: begin
                    next_state = ST_PREAMBLE;
                end
            endcase
        end
    end

    // ****************************************
    // Advertisement register
    // ****************************************
    always_comb begin
        next_advert = advert;
        if (adv_wr_en) begin
            // Only writable bits move; fixed bits
            next_advert = (advert & ~ADV_WRITE_MASK)
                        | (wr_word & ADV_WRITE_MASK);
        end
        if (soft_reset) begin
            next_advert = ADV_RESET;
        end
        next_advert[15:14] = 2'h0;
        next_advert[ADV_SEL_MSB:0] = ADV_SELECTOR;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            advert <= ADV_RESET;
        end else begin
            advert <= next_advert;
        end
    end

    // ****************************************
    // Read data driver
    // ****************************************
    // Released pin always rests low, also for writes and foreign frames
    always_comb begin
        next_rd_shift = rd_shift;
        next_mdio_out = mdio_out;
        next_mdio_oe_n = mdio_oe_n;
        if (load_rd) begin
            next_rd_shift = rd_word;
        end
        if (drive_zero) begin
            next_mdio_oe_n = 1'b0;
            next_mdio_out = 1'b0;
        end
        if (drive_next) begin
            next_mdio_out = rd_shift[15];
            next_rd_shift = {rd_shift[14:0], 1'b0};
        end
        if (release_pin) begin
            next_mdio_oe_n = 1'b1;
            next_mdio_out = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_shift <= 16'h0000;
            mdio_out <= 1'b0;
            mdio_oe_n <= 1'b1;
        end else begin
            rd_shift <= next_rd_shift;
            mdio_out <= next_mdio_out;
            mdio_oe_n <= next_mdio_oe_n;
        end
    end

    // ****************************************
    // Frame engine state
    // ****************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= ST_PREAMBLE;
            pre_cnt <= 6'h00;
            bit_cnt <= 4'h0;
            shift <= 16'h0000;
            op <= 2'h0;
            hit <= 1'b0;
            reg_num <= 5'h00;
        end else begin
            state <= next_state;
            pre_cnt <= next_pre_cnt;
            bit_cnt <= next_bit_cnt;
            shift <= next_shift;
            op <= next_op;
            hit <= next_hit;
            reg_num <= next_reg_num;
        end
    end
endmodule

// file: logic/phy_regs_pkg.sv
// Constants shared by the port management register block
package phy_regs_pkg;
    // ****************************************
    // Register numbers
    // ****************************************
    localparam logic [4:0] REG_BASIC_STATUS = 5'h01;
    localparam logic [4:0] REG_IDENT_HIGH = 5'h02;
    localparam logic [4:0] REG_IDENT_LOW = 5'h03;
    localparam logic [4:0] REG_ADVERT = 5'h04;

    // ****************************************
    // Advertisement layout and reset
    // ****************************************
    localparam logic [15:0] ADV_WRITE_MASK = 16'h3fe0;
    localparam logic [4:0] ADV_SELECTOR = 5'h01;
    localparam logic [15:0] ADV_RESET = 16'h01e1;
    localparam int ADV_SEL_MSB = 4;

    // ****************************************
    // Status bit positions
    // ****************************************
    localparam int STS_100TX_HD = 13;
    localparam int STS_10_HD = 11;
    localparam int STS_AN_DONE = 5;
    localparam int STS_LINK = 2;
    localparam int STS_JABBER = 1;
    localparam int STS_EXT_CAP = 0;

    // ****************************************
    // Management frame
    // ****************************************
    localparam logic [5:0] PREAMBLE_LEN = 6'h20;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [3:0] DATA_LAST = 4'hf;
    localparam logic [3:0] FIELD5_LAST = 4'h4;
    localparam logic [15:0] WORD_ZERO = 16'h0000;

    typedef enum logic [2:0] {
        ST_PREAMBLE,
        ST_START,
        ST_OP,
        ST_PHYAD,
        ST_REGAD,
        ST_TURN,
        ST_DATA
    } frame_state_t;
endpackage

// file: logic/latch_if.sv
// Status latch hand-off between frame engine and latch block
`timescale 1ns/1ps
interface latch_if;
    logic read_clear;
    logic link_raw;
    logic jabber_raw;
    logic link_latched;
    logic jabber_latched;

    modport engine (output read_clear, output link_raw, output jabber_raw,
                    input link_latched, input jabber_latched);
    modport latch (input read_clear, input link_raw, input jabber_raw,
                   output link_latched, output jabber_latched);
endinterface

// file: logic/pin_sync.sv
// Two-stage synchroniser for management pins
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,               // System clock
    input wire logic rst_n,             // Synchronous reset, active low
    input wire logic [WIDTH-1:0] d,     // Asynchronous pins
    output logic [WIDTH-1:0] q          // Synchronised levels
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic stage1;
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    stage1 <= 1'b0;
                    q[i] <= 1'b0;
                end else begin
                    stage1 <= d[i];
                    q[i] <= stage1;
                end
            end
        end
    endgenerate
endmodule

// file: logic/status_latch.sv
// Latch-low link and latch-high jabber status bits
`timescale 1ns/1ps
module status_latch (
    input wire logic clk,       // System clock
    input wire logic rst_n,     // Synchronous reset, active low
    input wire logic soft_reset, // Soft reset pulse
    latch_if.latch lat          // Latch hand-off
);
    logic next_link;
    logic next_jabber;

    always_comb begin
        next_link = lat.link_latched & lat.link_raw;
        next_jabber = lat.jabber_latched | lat.jabber_raw;
        if (lat.read_clear) begin
            next_link = lat.link_raw;
            next_jabber = lat.jabber_raw;
        end
        if (soft_reset) begin
            next_link = 1'b0;
            next_jabber = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lat.link_latched <= 1'b0;
            lat.jabber_latched <= 1'b0;
        end else begin
            lat.link_latched <= next_link;
            lat.jabber_latched <= next_jabber;
        end
    end
endmodule

// file: tb/phy_regs_monitor.sv
// Port-level checks for the register block
`timescale 1ns/1ps
module phy_regs_monitor (
    input wire logic clk,          // System clock
    input wire logic rst_n,        // Reset, active low
    input wire logic soft_reset,   // Soft reset pulse
    input wire logic mdc,          // Management clock
    input wire logic mdio_out,     // Driven data level
    input wire logic mdio_oe_n,    // Drive enable, low drives
    input wire logic [15:0] advert // Advertised word
);
    import phy_regs_pkg::*;
    logic mdc_q;
    logic [3:0] rise_age;
    logic [3:0] next_rise_age;
    // Cycles since the last mdc rise, saturating
    always_comb begin
        if (mdc && !mdc_q) begin
            next_rise_age = 4'h0;
        end else begin
            next_rise_age = (rise_age == 4'hf) ? rise_age : rise_age + 4'h1;
        end
    end
    always_ff @(posedge clk) begin
        mdc_q <= rst_n ? mdc : 1'b0;
        rise_age <= rst_n ? next_rise_age : 4'hf;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_drive_start;
        $fell(mdio_oe_n);
    endsequence
    sequence s_near_rise;
        rise_age inside {[1:6]};
    endsequence
    a_advert_fixed: assert property (advert[15:14] == 2'h0 && advert[4:0] == ADV_SELECTOR)
        else $error("advert fixed bits wrong");
    a_reset_advert: assert property ($rose(rst_n) |-> advert == ADV_RESET)
        else $error("advert not at reset value");
    a_soft_advert: assert property (soft_reset |=> advert == ADV_RESET)
        else $error("soft reset did not reload advert");
    a_release_idle: assert property ($rose(rst_n) |-> mdio_oe_n [*8])
        else $error("data pin driven after reset");
    a_turn_zero: assert property (s_drive_start |-> !mdio_out)
        else $error("drive did not start with zero");
    a_drive_edge: assert property (s_drive_start |-> s_near_rise)
        else $error("drive started away from mdc rise");
    a_idle_low: assert property (mdio_oe_n |-> !mdio_out)
        else $error("released pin not low");
    a_out_timing: assert property ($changed(mdio_out) |-> s_near_rise)
        else $error("data changed away from mdc rise");
    a_advert_edge: assert property ($changed(advert) && !$past(soft_reset) |-> s_near_rise)
        else $error("advert changed without a frame");
endmodule
bind phy_status_ident_advert_regs phy_regs_monitor mon_u (.clk(clk), .rst_n(rst_n),
    .soft_reset(soft_reset), .mdc(mdc), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n),
    .advert(advert));

// file: tb/mgmt_station.sv
// Station model sending serial management frames
`timescale 1ns/1ps
module mgmt_station (
    input wire logic clk,       // System clock
    output logic mdc,           // Management clock
    output logic mdio_wire,     // Resolved data line
    input wire logic mdio_out,  // Device data level
    input wire logic mdio_oe_n  // Device enable, low drives
);
    import phy_regs_pkg::*;
    logic drv = 1'b1;
    logic drv_en = 1'b0;
    // Line pulled up when nobody drives
    assign mdio_wire = !mdio_oe_n ? mdio_out : (drv_en ? drv : 1'b1);
    initial mdc = 1'b0;
    // One mdc period, line sampled before the rise
    task automatic clk_bit(input logic b, output logic s);
        drv = b;
        repeat (4) @(negedge clk);
        s = mdio_wire;
        mdc = 1'b1;
        repeat (4) @(negedge clk);
        mdc = 1'b0;
    endtask
    task automatic frame(input int pre, input logic [1:0] op, input logic [4:0] pa,
                         input logic [4:0] ra, input logic [15:0] wd,
                         output logic [15:0] rd);
        logic s;
        logic [13:0] hdr;
        hdr = {2'h1, op, pa, ra};
        drv_en = 1'b1;
        repeat (pre) clk_bit(1'b1, s);
        for (int i = 13; i >= 0; i--) clk_bit(hdr[i], s);
        if (op == OP_READ) drv_en = 1'b0;
        clk_bit(1'b1, s);
        clk_bit(1'b0, s);
        for (int i = 15; i >= 0; i--) begin
            clk_bit(wd[i], s);
            rd[i] = s;
        end
        drv_en = 1'b0;
        repeat (8) @(negedge clk);
    endtask
endmodule

// file: tb/test_phy_status_ident_advert_regs.sv
// Self-checking bench for the register block
`timescale 1ns/1ps
module test_phy_status_ident_advert_regs;
    import phy_regs_pkg::*;
    localparam logic [15:0] ID_HI = 16'h4c3b; // Arbitrary value
    localparam logic [15:0] ID_LO = 16'h9e07; // Arbitrary value
    localparam logic [4:0] ME = 5'h0b;
    localparam logic [15:0] STS = 16'h2801;
    logic clk = 1'b0;
    logic rst_n, soft_reset, link_ok, jabber_event, speed_10, an_complete;
    logic mdc, mdio_wire, mdio_out, mdio_oe_n;
    logic [15:0] advert, v;
    int fail_count = 0;
    int samples_checked = 0;
    always #4 clk = ~clk;
    phy_status_ident_advert_regs #(.IDENT_HIGH(ID_HI), .IDENT_LOW(ID_LO)) dut_u (
        .clk(clk), .rst_n(rst_n), .soft_reset(soft_reset), .port_addr(ME), .mdc(mdc),
        .mdio_in(mdio_wire), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n),
        .link_ok(link_ok), .jabber_event(jabber_event), .speed_10(speed_10),
        .an_complete(an_complete), .advert(advert));
    mgmt_station sta_u (.clk(clk), .mdc(mdc), .mdio_wire(mdio_wire),
        .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n));
    task automatic check16(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rd_chk(input string what, input logic [4:0] ra, input logic [15:0] exp);
        logic [15:0] r;
        sta_u.frame(32, OP_READ, ME, ra, WORD_ZERO, r);
        check16(what, exp, r);
    endtask
    task automatic wr(input int pre, input logic [4:0] pa, input logic [4:0] ra,
                      input logic [15:0] d);
        logic [15:0] r;
        sta_u.frame(pre, OP_WRITE, pa, ra, d, r);
    endtask
    task automatic pulse_jabber();
        jabber_event = 1'b1;
        @(negedge clk);
        jabber_event = 1'b0;
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        #500000;
        fail_count++;
        $display("unexpected watchdog expiry");
        summarize();
    end
    initial begin
        rst_n = 1'b0;
        soft_reset = 1'b0;
        link_ok = 1'b0;
        jabber_event = 1'b0;
        speed_10 = 1'b0;
        an_complete = 1'b0;
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        check16("advert port", ADV_RESET, advert);
        rd_chk("advert reg", REG_ADVERT, ADV_RESET);
        rd_chk("ident high", REG_IDENT_HIGH, ID_HI);
        rd_chk("ident low", REG_IDENT_LOW, ID_LO);
        rd_chk("status reset", REG_BASIC_STATUS, STS);
        $display("test reset values done");
        link_ok = 1'b1;
        an_complete = 1'b1;
        rd_chk("link held low", REG_BASIC_STATUS, STS | 16'h0020);
        rd_chk("link up", REG_BASIC_STATUS, STS | 16'h0024);
        link_ok = 1'b0;
        @(negedge clk);
        link_ok = 1'b1;
        rd_chk("link drop kept", REG_BASIC_STATUS, STS | 16'h0020);
        rd_chk("link restored", REG_BASIC_STATUS, STS | 16'h0024);
        pulse_jabber();
        rd_chk("jabber at 100", REG_BASIC_STATUS, STS | 16'h0024);
        speed_10 = 1'b1;
        pulse_jabber();
        rd_chk("jabber set", REG_BASIC_STATUS, STS | 16'h0026);
        rd_chk("jabber cleared", REG_BASIC_STATUS, STS | 16'h0024);
        $display("test status latches done");
        wr(32, ME, REG_ADVERT, 16'hffff);
        rd_chk("advert ones", REG_ADVERT, 16'h3fe1);
        check16("advert port ones", 16'h3fe1, advert);
        wr(32, ME, REG_ADVERT, WORD_ZERO);
        rd_chk("advert zeros", REG_ADVERT, 16'h0001);
        wr(32, ME, REG_ADVERT, 16'h24a0);
        rd_chk("advert mix", REG_ADVERT, 16'h24a1);
        wr(32, ME, REG_IDENT_HIGH, 16'hffff);
        rd_chk("ident high kept", REG_IDENT_HIGH, ID_HI);
        wr(32, ME, REG_IDENT_LOW, WORD_ZERO);
        rd_chk("ident low kept", REG_IDENT_LOW, ID_LO);
        wr(32, ME, REG_BASIC_STATUS, 16'hffff);
        rd_chk("status kept", REG_BASIC_STATUS, STS | 16'h0024);
        $display("test writes done");
        wr(32, ME ^ 5'h01, REG_ADVERT, WORD_ZERO);
        rd_chk("foreign write", REG_ADVERT, 16'h24a1);
        sta_u.frame(32, OP_READ, ME ^ 5'h01, REG_ADVERT, WORD_ZERO, v);
        check16("foreign read", 16'hffff, v);
        wr(20, ME, REG_ADVERT, WORD_ZERO);
        rd_chk("short preamble", REG_ADVERT, 16'h24a1);
        rd_chk("unmapped", 5'h05, WORD_ZERO);
        soft_reset = 1'b1;
        @(negedge clk);
        soft_reset = 1'b0;
        @(negedge clk);
        check16("soft reset advert", ADV_RESET, advert);
        wr(32, ME, REG_ADVERT, 16'h2000);
        rst_n = 1'b0;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        check16("reset advert", ADV_RESET, advert);
        rd_chk("status after reset", REG_BASIC_STATUS, STS | 16'h0020);
        $display("test refusals done");
        summarize();
    end
endmodule
